//--- src/ccc_core.sv
// Core slice executing call, clear, watchdog clear and invert operations
// Function
// RULE_01 - Call pushes program counter plus one
// RULE_02 - Call loads target, two cycles, flags kept
// RULE_03 - Zero-memory writes 00H, flags kept
// RULE_04 - Bit clear zeroes one bit only
// RULE_05 - Watchdog clear resets counter and two flags
// RULE_06 - Invert-memory writes complement, updates null flag
// RULE_07 - Invert-to-working fills working register, memory kept
// RULE_08 - Clear and invert operations take one cycle
`timescale 1ns/1ps
module ccc_core
    import ccc_pkg::*;
#(
    parameter int PC_W = CCC_PC_W,
    parameter int ADDR_W = CCC_ADDR_W,
    parameter int STACK_DEPTH = CCC_STACK_DEPTH,
    parameter logic [CCC_WDT_W-1:0] WDT_LIMIT = CCC_WDT_LIMIT
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic instr_valid,
    input ccc_op_t instr_op,
    input wire logic [ADDR_W-1:0] instr_addr,
    input wire logic [CCC_BIT_W-1:0] instr_bit,
    input wire logic [PC_W-1:0] instr_target,
    input wire logic sleep_entry_event,
    input wire logic mem_load_en,
    input wire logic [ADDR_W-1:0] mem_load_addr,
    input wire logic [CCC_DATA_W-1:0] mem_load_data,
    input wire logic [ADDR_W-1:0] mem_peek_addr,
    output logic [CCC_DATA_W-1:0] mem_peek_data,
    output logic [PC_W-1:0] pc,
    output logic [CCC_DATA_W-1:0] working_register,
    output logic null_flag,
    output logic watchdog_expiry_flag,
    output logic sleep_entry_flag,
    output logic [CCC_WDT_W-1:0] wdt_count,
    output logic [PC_W-1:0] stack_top,
    output logic [$clog2(STACK_DEPTH+1)-1:0] stack_level,
    output logic busy,
    output logic done
);
    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam int LVL_W = $clog2(STACK_DEPTH+1);
    localparam int MEM_DEPTH = 2 ** ADDR_W;
    localparam logic [SP_W-1:0] SP_STEP = SP_W'(1);
    localparam logic [SP_W-1:0] SP_ZERO = SP_W'(0);
    localparam logic [LVL_W-1:0] LVL_STEP = LVL_W'(1);
    localparam logic [LVL_W-1:0] LVL_ZERO = LVL_W'(0);
    localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(STACK_DEPTH);

    ccc_state_t state;
    ccc_state_t next_state;
    logic [CCC_DATA_W-1:0] data_mem [MEM_DEPTH];
    logic [PC_W-1:0] ret_stack [STACK_DEPTH];
    logic [SP_W-1:0] stack_ptr;
    logic [PC_W-1:0] call_target;
    ccc_dec_if dec_bus ();

    // New work only while idle; a call blocks for its second cycle
    wire accept = instr_valid && (state == CCC_ST_IDLE);

    ccc_decode u_decode (
        .accept(accept),
        .op(instr_op),
        .dec(dec_bus.dec)
    );

    wire [CCC_DATA_W-1:0] operand = data_mem[instr_addr];
    wire [CCC_DATA_W-1:0] inverted = ~operand;
    wire [CCC_DATA_W-1:0] bit_mask = CCC_BIT_ONE << instr_bit;
    wire [PC_W-1:0] pc_plus_one = pc + CCC_PC_STEP;
    wire wdt_terminal = (wdt_count == WDT_LIMIT);
    wire stack_full = (stack_level == LVL_FULL);

    // RULE_03 Byte forced zero
    wire [CCC_DATA_W-1:0] zero_value = CCC_ZERO_BYTE;
    // RULE_04 Selected bit cleared
    wire [CCC_DATA_W-1:0] bclr_value = operand & ~bit_mask;
    // RULE_06 Complement written back
    wire [CCC_DATA_W-1:0] inv_value = inverted;

    logic [CCC_DATA_W-1:0] next_mem_value;
    always_comb begin
        next_mem_value = operand;
        if (dec_bus.zero_memory_op) begin
            next_mem_value = zero_value;
        end else if (dec_bus.bit_clear_op) begin
            next_mem_value = bclr_value;
        end else if (dec_bus.invert_memory_op) begin
            next_mem_value = inv_value;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            CCC_ST_IDLE: begin
                if (dec_bus.call_op) begin
                    next_state = CCC_ST_CALL_LOAD;
                end
            end
            CCC_ST_CALL_LOAD: begin
                next_state = CCC_ST_IDLE;
            end
            default: begin
                next_state = CCC_ST_IDLE;
            end
        endcase
    end

    // RULE_02 Two-cycle call sequence
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= CCC_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // RULE_07 Data memory untouched by invert-to-working
    always_ff @(posedge clk_sys) begin
        if (dec_bus.memory_write) begin
            data_mem[instr_addr] <= next_mem_value;
        end else if (mem_load_en && !instr_valid) begin
            data_mem[mem_load_addr] <= mem_load_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        mem_peek_data <= data_mem[mem_peek_addr];
    end

    // RULE_01 Return address pushed
    always_ff @(posedge clk_sys) begin
        if (dec_bus.call_op) begin
            ret_stack[stack_ptr] <= pc_plus_one;
        end
    end

    // Circular stack: overflow overwrites the oldest entry
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stack_ptr <= SP_ZERO;
            stack_level <= LVL_ZERO;
            stack_top <= CCC_PC_RESET;
        end else if (dec_bus.call_op) begin
            stack_ptr <= stack_ptr + SP_STEP;
            stack_top <= pc_plus_one;
            if (!stack_full) begin
                stack_level <= stack_level + LVL_STEP;
            end
        end
    end

    // RULE_02 Target loaded in second cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pc <= CCC_PC_RESET;
            call_target <= CCC_PC_RESET;
        end else if (dec_bus.call_op) begin
            call_target <= instr_target;
        end else if (state == CCC_ST_CALL_LOAD) begin
            pc <= call_target;
        end else if (accept) begin
            pc <= pc_plus_one;
        end
    end

    // RULE_07 Complement into working register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            working_register <= CCC_ZERO_BYTE;
        end else if (dec_bus.invert_into_working_op) begin
            working_register <= inverted;
        end
    end

    // RULE_06 Null flag from complement
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            null_flag <= 1'b0;
        end else if (dec_bus.null_update) begin
            null_flag <= (inverted == CCC_ZERO_BYTE);
        end
    end

    // RULE_05 Watchdog counter restarted
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wdt_count <= CCC_WDT_ZERO;
        end else if (dec_bus.watchdog_clear_op || wdt_terminal) begin
            wdt_count <= CCC_WDT_ZERO;
        end else begin
            wdt_count <= wdt_count + CCC_WDT_STEP;
        end
    end

    // RULE_05 Expiry and sleep flags cleared
    // A same-cycle sleep entry beats the clear; a same-cycle clear beats the expiry set
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            watchdog_expiry_flag <= 1'b0;
            sleep_entry_flag <= 1'b0;
        end else begin
            if (wdt_terminal && !dec_bus.watchdog_clear_op) begin
                watchdog_expiry_flag <= 1'b1;
            end else if (dec_bus.watchdog_clear_op) begin
                watchdog_expiry_flag <= 1'b0;
            end
            if (sleep_entry_event) begin
                sleep_entry_flag <= 1'b1;
            end else if (dec_bus.watchdog_clear_op) begin
                sleep_entry_flag <= 1'b0;
            end
        end
    end

    // RULE_08 Single-cycle completion
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            busy <= (next_state != CCC_ST_IDLE);
            done <= (accept && !dec_bus.call_op)
                || (state == CCC_ST_CALL_LOAD);
        end
    end
endmodule : ccc_core

//--- src/ccc_pkg.sv
// Shared constants and types for the call, clear and invert core slice
package ccc_pkg;
    localparam int CCC_PC_W = 13;
    localparam int CCC_DATA_W = 8;
    localparam int CCC_ADDR_W = 8;
    localparam int CCC_BIT_W = 3;
    localparam int CCC_STACK_DEPTH = 8;
    localparam int CCC_WDT_W = 16;
    localparam logic [CCC_WDT_W-1:0] CCC_WDT_LIMIT = 16'hFFFF;
    localparam logic [CCC_WDT_W-1:0] CCC_WDT_ZERO = 16'h0000;
    localparam logic [CCC_WDT_W-1:0] CCC_WDT_STEP = 16'h0001;
    localparam logic [CCC_PC_W-1:0] CCC_PC_RESET = 13'h0000;
    localparam logic [CCC_PC_W-1:0] CCC_PC_STEP = 13'h0001;
    localparam logic [CCC_DATA_W-1:0] CCC_ZERO_BYTE = 8'h00;
    localparam logic [CCC_DATA_W-1:0] CCC_BIT_ONE = 8'h01;

    typedef enum logic [2:0] {
        CCC_OP_NOP,
        CCC_OP_CALL,
        CCC_OP_ZERO_MEMORY,
        CCC_OP_BIT_CLEAR,
        CCC_OP_WATCHDOG_CLEAR,
        CCC_OP_INVERT_MEMORY,
        CCC_OP_INVERT_INTO_WORKING
    } ccc_op_t;

    typedef enum {
        CCC_ST_IDLE,
        CCC_ST_CALL_LOAD
    } ccc_state_t;
endpackage : ccc_pkg

//--- src/ccc_dec_if.sv
// Decoded operation strobes between decoder and core
`timescale 1ns/1ps
interface ccc_dec_if;
    logic call_op;
    logic zero_memory_op;
    logic bit_clear_op;
    logic watchdog_clear_op;
    logic invert_memory_op;
    logic invert_into_working_op;
    logic memory_write;
    logic null_update;

    modport dec (
        output call_op,
        output zero_memory_op,
        output bit_clear_op,
        output watchdog_clear_op,
        output invert_memory_op,
        output invert_into_working_op,
        output memory_write,
        output null_update
    );

    modport core (
        input call_op,
        input zero_memory_op,
        input bit_clear_op,
        input watchdog_clear_op,
        input invert_memory_op,
        input invert_into_working_op,
        input memory_write,
        input null_update
    );
endinterface : ccc_dec_if

//--- src/ccc_decode.sv
// Opcode decoder for the call, clear and invert operations
`timescale 1ns/1ps
module ccc_decode
    import ccc_pkg::*;
(
    input wire logic accept,
    input ccc_op_t op,
    ccc_dec_if.dec dec
);
    wire is_call = accept && (op == CCC_OP_CALL);
    wire is_zero = accept && (op == CCC_OP_ZERO_MEMORY);
    wire is_bclr = accept && (op == CCC_OP_BIT_CLEAR);
    wire is_wdt = accept && (op == CCC_OP_WATCHDOG_CLEAR);
    wire is_inv = accept && (op == CCC_OP_INVERT_MEMORY);
    wire is_inva = accept && (op == CCC_OP_INVERT_INTO_WORKING);

    assign dec.call_op = is_call;
    assign dec.zero_memory_op = is_zero;
    assign dec.bit_clear_op = is_bclr;
    assign dec.watchdog_clear_op = is_wdt;
    assign dec.invert_memory_op = is_inv;
    assign dec.invert_into_working_op = is_inva;
    // Only these three write the byte back
    assign dec.memory_write = is_zero || is_bclr || is_inv;
    assign dec.null_update = is_inv || is_inva;
endmodule : ccc_decode

//--- verif/ccc_core_assertions.sv
// Checker for the call, clear and invert core slice
`timescale 1ns/1ps
module ccc_core_chk
    import ccc_pkg::*;
#(
    parameter int PC_W = CCC_PC_W,
    parameter int ADDR_W = CCC_ADDR_W,
    parameter int STACK_DEPTH = CCC_STACK_DEPTH,
    parameter logic [CCC_WDT_W-1:0] WDT_LIMIT = CCC_WDT_LIMIT
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic instr_valid,
    input ccc_op_t instr_op,
    input wire logic [PC_W-1:0] instr_target,
    input wire logic sleep_entry_event,
    input logic [PC_W-1:0] pc,
    input logic [CCC_DATA_W-1:0] working_register,
    input logic null_flag,
    input logic watchdog_expiry_flag,
    input logic sleep_entry_flag,
    input logic [CCC_WDT_W-1:0] wdt_count,
    input logic [PC_W-1:0] stack_top,
    input logic busy,
    input logic done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire take = instr_valid && !busy;
    wire call_go = take && instr_op == CCC_OP_CALL;
    wire one_go = take && instr_op != CCC_OP_CALL;
    wire clr_go = take && (instr_op == CCC_OP_ZERO_MEMORY
        || instr_op == CCC_OP_BIT_CLEAR);
    wire wdt_go = take && instr_op == CCC_OP_WATCHDOG_CLEAR;
    wire inv_go = take && instr_op == CCC_OP_INVERT_INTO_WORKING;
    sequence call_load;
        busy && !done;
    endsequence
    sequence call_land;
        !busy && done;
    endsequence
    chk_call_push: assert property (
        call_go |=> stack_top == $past(pc) + CCC_PC_STEP
    ) else $error("call pushed wrong return address");
    chk_call_jump: assert property (
        call_go |=> call_load ##1 call_land ##0
            pc == $past(instr_target, 2)
    ) else $error("call did not reach target in two cycles");
    chk_call_flags: assert property (
        call_go |=> $stable(null_flag) [*2]
    ) else $error("call changed null flag");
    chk_one_cycle: assert property (
        one_go |=> done && !busy && pc == $past(pc) + CCC_PC_STEP
    ) else $error("single-cycle op not done in one cycle");
    chk_clear_flags: assert property (
        clr_go |=> $stable(null_flag)
    ) else $error("clear op changed null flag");
    chk_wdt_clear: assert property (
        wdt_go && !sleep_entry_event && wdt_count != WDT_LIMIT |=>
            wdt_count == CCC_WDT_ZERO && !watchdog_expiry_flag
            && !sleep_entry_flag && $stable(null_flag)
    ) else $error("watchdog clear left counter or flags");
    chk_wdt_wrap: assert property (
        wdt_count == WDT_LIMIT && !wdt_go |=>
            wdt_count == CCC_WDT_ZERO && watchdog_expiry_flag
    ) else $error("watchdog wrap did not set expiry");
    chk_inv_null: assert property (
        inv_go |=> null_flag == (working_register == CCC_ZERO_BYTE)
    ) else $error("null flag does not match working register");
    chk_done_cause: assert property (
        done |-> $past(busy) || $past(one_go)
    ) else $error("done without a finished operation");
endmodule : ccc_core_chk

bind ccc_core ccc_core_chk #(.PC_W(PC_W), .ADDR_W(ADDR_W),
    .STACK_DEPTH(STACK_DEPTH), .WDT_LIMIT(WDT_LIMIT)) i_ccc_core_chk (
    .clk_sys, .reset, .instr_valid, .instr_op, .instr_target,
    .sleep_entry_event, .pc, .working_register, .null_flag,
    .watchdog_expiry_flag, .sleep_entry_flag, .wdt_count, .stack_top,
    .busy, .done);

//--- verif/tb_call_clear_complement_ops.sv
// Self-checking bench for the call, clear and invert core slice
`timescale 1ns/1ps
module tb_call_clear_complement_ops
    import ccc_pkg::*;
();
    // Short watchdog period so wraps happen within the run
    localparam logic [CCC_WDT_W-1:0] LIM = 16'h0010;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic instr_valid = 1'b0, sleep_entry_event = 1'b0, mem_load_en = 1'b0;
    ccc_op_t instr_op = CCC_OP_NOP;
    logic [7:0] instr_addr = 8'h00, mem_load_addr = 8'h00;
    logic [7:0] mem_load_data = 8'h00, mem_peek_addr = 8'h00;
    logic [2:0] instr_bit = 3'h0;
    logic [12:0] instr_target = 13'h0000, exp_pc = 13'h0000;
    logic [7:0] mem_peek_data, working_register;
    logic [12:0] pc, stack_top;
    logic [3:0] stack_level;
    logic [15:0] wdt_count;
    logic null_flag, watchdog_expiry_flag, sleep_entry_flag, busy, done;
    int n_fail = 0;
    int samples_checked = 0;
    always #2.5 clk_sys = ~clk_sys;
    ccc_core #(.WDT_LIMIT(LIM)) i_ccc_core (.clk_sys, .reset, .instr_valid,
        .instr_op, .instr_addr, .instr_bit, .instr_target, .sleep_entry_event,
        .mem_load_en, .mem_load_addr, .mem_load_data, .mem_peek_addr,
        .mem_peek_data, .pc, .working_register, .null_flag,
        .watchdog_expiry_flag, .sleep_entry_flag, .wdt_count, .stack_top,
        .stack_level, .busy, .done);
    task automatic cmp_word(logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (e !== g) begin
            n_fail++;
            $display("wrong value t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp_word
    task automatic cmp_byte(logic [7:0] e, logic [7:0] g);
        cmp_word({8'h00, e}, {8'h00, g});
    endtask : cmp_byte
    task automatic cmp_pc(logic [12:0] e, logic [12:0] g);
        cmp_word({3'h0, e}, {3'h0, g});
    endtask : cmp_pc
    task automatic cmp_flag(logic e, logic g);
        cmp_word({15'h0000, e}, {15'h0000, g});
    endtask : cmp_flag
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick
    // Leaves the strobe up when more ops follow back to back
    task automatic op_go(ccc_op_t o, logic [7:0] a, logic [2:0] b, logic last);
        instr_valid = 1'b1;
        instr_op = o;
        instr_addr = a;
        instr_bit = b;
        tick();
        if (last) begin
            instr_valid = 1'b0;
        end
        if (o != CCC_OP_CALL) exp_pc = exp_pc + 13'h0001;
    endtask : op_go
    task automatic load(logic [7:0] a, logic [7:0] d);
        mem_load_en = 1'b1;
        mem_load_addr = a;
        mem_load_data = d;
        tick();
        mem_load_en = 1'b0;
    endtask : load
    task automatic peek(logic [7:0] a, output logic [7:0] d);
        mem_peek_addr = a;
        tick();
        d = mem_peek_data;
    endtask : peek
    task automatic t_invert();
        logic [7:0] d;
        load(8'h30, 8'hFF);
        op_go(CCC_OP_INVERT_MEMORY, 8'h30, 3'h0, 1'b0);
        cmp_flag(1'b1, null_flag);
        op_go(CCC_OP_INVERT_MEMORY, 8'h30, 3'h0, 1'b1);
        cmp_flag(1'b0, null_flag);
        cmp_flag(1'b1, done);
        peek(8'h30, d);
        cmp_byte(8'hFF, d);
        load(8'h31, 8'hFF);
        op_go(CCC_OP_INVERT_INTO_WORKING, 8'h31, 3'h0, 1'b1);
        cmp_byte(8'h00, working_register);
        cmp_flag(1'b1, null_flag);
        peek(8'h31, d);
        cmp_byte(8'hFF, d);
    endtask : t_invert
    task automatic t_zero();
        logic [7:0] d;
        load(8'h21, 8'h5A);
        op_go(CCC_OP_ZERO_MEMORY, 8'h21, 3'h0, 1'b1);
        cmp_pc(exp_pc, pc);
        cmp_flag(1'b0, null_flag);
        peek(8'h21, d);
        cmp_byte(CCC_ZERO_BYTE, d);
    endtask : t_zero
    task automatic t_bits();
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            load(8'h40, 8'hFF);
            op_go(CCC_OP_BIT_CLEAR, 8'h40, i[2:0], 1'b1);
            cmp_flag(1'b1, null_flag);
            peek(8'h40, d);
            cmp_byte(~(8'h01 << i), d);
        end
    endtask : t_bits
    task automatic t_call();
        logic [7:0] d;
        instr_target = 13'h1ABC;
        op_go(CCC_OP_CALL, 8'h40, 3'h0, 1'b0);
        cmp_pc(exp_pc + 13'h0001, stack_top);
        cmp_byte(8'h01, {4'h0, stack_level});
        cmp_flag(1'b1, busy);
        // A request while busy must be dropped
        instr_op = CCC_OP_ZERO_MEMORY;
        tick();
        instr_valid = 1'b0;
        exp_pc = 13'h1ABC;
        cmp_pc(exp_pc, pc);
        cmp_flag(1'b1, done);
        cmp_flag(1'b1, null_flag);
        peek(8'h40, d);
        cmp_byte(8'h7F, d);
    endtask : t_call
    task automatic t_wdt();
        int k;
        sleep_entry_event = 1'b1;
        tick();
        sleep_entry_event = 1'b0;
        cmp_flag(1'b1, sleep_entry_flag);
        // Clear away from the terminal count, where the clear beats the expiry set
        k = 0;
        while (wdt_count !== 16'h0003 && k < 100) begin
            tick();
            k++;
        end
        cmp_flag(1'b1, watchdog_expiry_flag);
        op_go(CCC_OP_WATCHDOG_CLEAR, 8'h00, 3'h0, 1'b1);
        cmp_word(CCC_WDT_ZERO, wdt_count);
        cmp_flag(1'b0, watchdog_expiry_flag);
        cmp_flag(1'b0, sleep_entry_flag);
        cmp_flag(1'b1, null_flag);
        cmp_pc(exp_pc, pc);
    endtask : t_wdt
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (3) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        // Null flag still low from reset, so a stray update shows
        t_zero();
        t_invert();
        t_bits();
        t_call();
        t_wdt();
        wrap_up();
    end
    initial begin
        #20000;
        n_fail++;
        wrap_up();
    end
endmodule : tb_call_clear_complement_ops
